// ===== include/pin_mux_map.svh
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH

// ==========================================================
// Port widths
`define P3_W 10
`define P4_W 3
`define P5_W 6
`define P6_W 16
`define P7_W 16
`define P8_W 2
`define IO_W 37
`define IN_W 53

// ==========================================================
// Base of each port in the merged pin vector
`define P3_B 0
`define P4_B 10
`define P5_B 13
`define P6_B 19
`define P8_B 35
`define P7_B 37

// ==========================================================
// Open-drain and alternate-mode masks
`define P3_OD_FIXED 10'h3c0
`define P4_OD_SEL 3'h6
`define P5_OD_SEL 6'h30
`define P6_OD_SEL 16'h0180
`define P3_ALT_MASK 10'h028
`define P6_ALT_MASK 16'h2000

// ==========================================================
// Peripheral bit positions within each port
`define P3_TX 0
`define P3_RX 1
`define P3_BAUD 2
`define P3_TMR 3
`define P3_TO_A 3
`define P3_TO_B 5
`define P3_SDA 8
`define P3_SCL 9
`define P4_SI 0
`define P4_SO 1
`define P4_SCK 2
`define P5_TI16 0
`define P5_TI8 1
`define P5_TO8 2
`define P5_SI 3
`define P5_SO 4
`define P5_SCK 5
`define P6_RTP 0
`define P6_SI 6
`define P6_SO 7
`define P6_SCK 8
`define P6_TI 9
`define P6_TO 13
`define P8_TX 0
`define P8_RX 1

// ==========================================================
// Reset values
`define OUT_RST 37'h0
`define OE_N_RST 37'h1f_ffff_ffff
`define IN_RST 53'h0

`endif

// ===== include/pin_mux_pkg.sv
`include "pin_mux_map.svh"

package pin_mux_pkg;
    typedef logic [`P3_W-1:0] p3_t;
    typedef logic [`P4_W-1:0] p4_t;
    typedef logic [`P5_W-1:0] p5_t;
    typedef logic [`P6_W-1:0] p6_t;
    typedef logic [`P7_W-1:0] p7_t;
    typedef logic [`P8_W-1:0] p8_t;
    typedef logic [`IO_W-1:0] io_t;
    typedef logic [`IN_W-1:0] in_t;
    typedef struct packed {
        logic val;
        logic drv;
    } pin_s;
endpackage : pin_mux_pkg

// ===== testbench/pin_board_model.sv
`timescale 1ns/1ps
module pin_board #(
    parameter int W = 1
) (
    input wire logic [W-1:0] o_i,
    input wire logic [W-1:0] n_i,
    input wire logic [W-1:0] e_i,
    input wire logic [W-1:0] x_i,
    output logic [W-1:0] p_o
);
    // ==========
    // Pin level: device drive, else board driver, else pull-up
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            p_o[i] = !n_i[i] ? o_i[i] : (e_i[i] ? x_i[i] : 1'b1);
        end
    end
endmodule : pin_board

// ===== testbench/pin_mux_chk.sv
`timescale 1ns/1ps
module pin_mux_chk (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire pin_mux_pkg::p3_t port3_direction_i,
    input wire pin_mux_pkg::p3_t port3_function_select_i,
    input wire pin_mux_pkg::p3_t port3_alt_mode_select_i,
    input wire pin_mux_pkg::p3_t port3_latch_i,
    input wire logic [9:0] port3_pad_out_o,
    input wire logic [9:0] port3_pad_oe_n_o,
    input wire pin_mux_pkg::p4_t port4_function_select_i,
    input wire pin_mux_pkg::p4_t port4_open_drain_i,
    input wire logic [2:0] port4_pad_oe_n_o,
    input wire pin_mux_pkg::p6_t port6_function_select_i,
    input wire pin_mux_pkg::p6_t port6_alt_mode_select_i,
    input wire logic [15:0] port6_pad_out_o,
    input wire logic [15:0] port6_pad_oe_n_o,
    input wire pin_mux_pkg::p7_t port7_pad_in_i,
    input wire logic [15:0] port7_read_o,
    input wire logic [15:0] converter_analog_inputs_o,
    input wire logic async_serial0_transmit_i,
    input wire logic [1:0] timer16_out_a_i,
    input wire logic clocked_serial00_out_i,
    input wire logic [1:0] timer16_out_c_i
);
    import pin_mux_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // ==========
    // Assertions
    chk_p3_port_drive: assert property (
        !port3_function_select_i[2] && !port3_direction_i[2] |=>
        !port3_pad_oe_n_o[2] && port3_pad_out_o[2] == $past(port3_latch_i[2]))
        else $error("port3 bit2 not driving latch");
    chk_p3_input_off: assert property (
        !port3_function_select_i[1] && port3_direction_i[1] |=> port3_pad_oe_n_o[1])
        else $error("port3 bit1 driven as input");
    chk_p3_od_fixed: assert property (
        (~port3_pad_oe_n_o[9:6] & port3_pad_out_o[9:6]) == 4'h0)
        else $error("port3 high bits drive high");
    chk_p4_od_sel: assert property (
        port4_function_select_i[1] && port4_open_drain_i[1] && clocked_serial00_out_i
        |=> port4_pad_oe_n_o[1]) else $error("port4 bit1 drives high in open-drain");
    chk_tx_route: assert property (
        port3_function_select_i[0] |=> !port3_pad_oe_n_o[0] &&
        port3_pad_out_o[0] == $past(async_serial0_transmit_i)) else $error("transmit not routed");
    chk_p3_alt_out: assert property (
        port3_function_select_i[3] && port3_alt_mode_select_i[3] |=> !port3_pad_oe_n_o[3] &&
        port3_pad_out_o[3] == $past(timer16_out_a_i[0])) else $error("port3 bit3 mode 2 wrong");
    chk_p6_alt_out: assert property (
        port6_function_select_i[13] && port6_alt_mode_select_i[13] |=> !port6_pad_oe_n_o[13] &&
        port6_pad_out_o[13] == $past(timer16_out_c_i[1])) else $error("port6 bit13 mode 2 wrong");
    chk_p7_follow: assert property (
        (!srst_i && $stable(port7_pad_in_i)) [*7] |-> port7_read_o == port7_pad_in_i &&
        converter_analog_inputs_o == port7_pad_in_i) else $error("port7 read wrong");
    cover property (!port3_function_select_i[2] && !port3_direction_i[2]);
    cover property (port3_function_select_i[3] && port3_alt_mode_select_i[3]);
    cover property (port4_function_select_i[1] && port4_open_drain_i[1]);
endmodule : pin_mux_chk

bind port3_to_port8_pin_mux pin_mux_chk chk (.*);

// ===== testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    import pin_mux_pkg::*;
    logic clk_i, srst_i;
    int mismatches, compares;
    p3_t port3_direction_i, port3_function_select_i, port3_alt_mode_select_i, port3_latch_i;
    p3_t port3_pad_in_i, port3_pad_out_o, port3_pad_oe_n_o, port3_read_o, e3, x3;
    p4_t port4_direction_i, port4_function_select_i, port4_open_drain_i, port4_latch_i;
    p4_t port4_pad_in_i, port4_pad_out_o, port4_pad_oe_n_o, port4_read_o, e4, x4;
    p5_t port5_direction_i, port5_function_select_i, port5_alt_mode_select_i, port5_latch_i;
    p5_t port5_open_drain_i, port5_pad_in_i, port5_pad_out_o, port5_pad_oe_n_o, port5_read_o;
    p5_t key_return_config_i, key_interrupt_inputs_o, realtime_output_group0_i, e5, x5;
    p6_t port6_direction_i, port6_function_select_i, port6_alt_mode_select_i, port6_latch_i;
    p6_t port6_open_drain_i, port6_pad_in_i, port6_pad_out_o, port6_pad_oe_n_o, port6_read_o;
    p6_t e6, x6;
    p7_t port7_pad_in_i, port7_read_o, converter_analog_inputs_o;
    p8_t port8_direction_i, port8_function_select_i, port8_alt_mode_select_i, port8_latch_i;
    p8_t port8_pad_in_i, port8_pad_out_o, port8_pad_oe_n_o, port8_read_o, e8, x8;
    logic [1:0] timer16_out_a_i, timer16_out_c_i;
    logic [2:0] timer16_in_a_o;
    logic [3:0] timer16_in_c_o;
    logic [5:0] realtime_output_group1_i;
    logic [35:0] periph_drive;
    logic async_serial0_transmit_i, async_serial0_receive_o, async_serial0_baud_clock_in_o;
    logic two_wire0_data_out_i, two_wire0_data_oe_i, two_wire0_data_in_o;
    logic two_wire0_clock_out_i, two_wire0_clock_oe_i, two_wire0_clock_in_o;
    logic clocked_serial00_out_i, clocked_serial00_in_o, clocked_serial00_clock_out_i;
    logic clocked_serial00_clock_oe_i, clocked_serial00_clock_in_o, timer16_in_b_o;
    logic timer8_in_o, timer8_out_i, clocked_serial_a0_out_i, clocked_serial_a0_in_o;
    logic clocked_serial_a0_clock_out_i, clocked_serial_a0_clock_oe_i;
    logic clocked_serial_a0_clock_in_o, clocked_serial02_out_i, clocked_serial02_in_o;
    logic clocked_serial02_clock_out_i, clocked_serial02_clock_oe_i, clocked_serial02_clock_in_o;
    logic async_serial2_transmit_i, async_serial2_receive_o;
    logic two_wire1_data_out_i, two_wire1_data_oe_i, two_wire1_data_in_o;
    logic two_wire1_clock_out_i, two_wire1_clock_oe_i, two_wire1_clock_in_o;
    // ==========
    // Peripheral drive vector, design and board pins
    assign {async_serial0_transmit_i, timer16_out_a_i, two_wire0_data_out_i, two_wire0_data_oe_i,
        two_wire0_clock_out_i, two_wire0_clock_oe_i, clocked_serial00_out_i,
        clocked_serial00_clock_out_i, clocked_serial00_clock_oe_i, timer8_out_i,
        clocked_serial_a0_out_i, clocked_serial_a0_clock_out_i, clocked_serial_a0_clock_oe_i,
        realtime_output_group0_i, realtime_output_group1_i, clocked_serial02_out_i,
        clocked_serial02_clock_out_i, clocked_serial02_clock_oe_i, timer16_out_c_i,
        async_serial2_transmit_i, two_wire1_data_out_i, two_wire1_data_oe_i,
        two_wire1_clock_out_i, two_wire1_clock_oe_i} = periph_drive;
    port3_to_port8_pin_mux dut (.*);
    pin_board #(.W(10)) b3 (.o_i(port3_pad_out_o), .n_i(port3_pad_oe_n_o), .e_i(e3), .x_i(x3),
        .p_o(port3_pad_in_i));
    pin_board #(.W(3)) b4 (.o_i(port4_pad_out_o), .n_i(port4_pad_oe_n_o), .e_i(e4), .x_i(x4),
        .p_o(port4_pad_in_i));
    pin_board #(.W(6)) b5 (.o_i(port5_pad_out_o), .n_i(port5_pad_oe_n_o), .e_i(e5), .x_i(x5),
        .p_o(port5_pad_in_i));
    pin_board #(.W(16)) b6 (.o_i(port6_pad_out_o), .n_i(port6_pad_oe_n_o), .e_i(e6), .x_i(x6),
        .p_o(port6_pad_in_i));
    pin_board #(.W(2)) b8 (.o_i(port8_pad_out_o), .n_i(port8_pad_oe_n_o), .e_i(e8), .x_i(x8),
        .p_o(port8_pad_in_i));
    always #2 clk_i = ~clk_i;
    // ==========
    // Helpers
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic end_of_test();
        if (mismatches == 0 && compares > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // ==========
    // Scenarios
    task automatic port_mode();
        @(posedge clk_i);
        {port3_direction_i, port4_direction_i, port5_direction_i, port6_direction_i} <= '0;
        port3_latch_i <= 10'h2a5;
        {port4_latch_i, port4_open_drain_i} <= {3'h7, 3'h6};
        {port5_latch_i, port5_open_drain_i} <= {6'h3f, 6'h3f};
        {port6_latch_i, port6_open_drain_i} <= {16'hffff, 16'hffff};
        settle(7);
        `CHK(port3_pad_oe_n_o, 10'h280)
        `CHK(port3_pad_out_o & ~port3_pad_oe_n_o, 10'h025)
        `CHK(port3_read_o, 10'h2a5)
        `CHK(port4_pad_oe_n_o, 3'h6)
        `CHK(port5_pad_oe_n_o, 6'h30)
        `CHK(port6_pad_oe_n_o, 16'h0180)
        @(posedge clk_i);
        port3_direction_i <= 10'h3f0;
        settle(2);
        `CHK(port3_pad_oe_n_o, 10'h3f0)
    endtask : port_mode
    task automatic control_mode1();
        @(posedge clk_i);
        {port3_function_select_i, port4_function_select_i, port5_function_select_i} <= '1;
        {port6_function_select_i, port8_function_select_i} <= '1;
        {port3_direction_i, port3_latch_i, port6_latch_i} <= {10'h3ff, 10'h0, 16'h0};
        {port4_open_drain_i, port5_open_drain_i, port6_open_drain_i} <= '0;
        periph_drive <= '1;
        settle(7);
        `CHK({port3_pad_oe_n_o, port3_pad_out_o & ~port3_pad_oe_n_o}, {10'h3fe, 10'h001})
        `CHK({port4_pad_oe_n_o, port4_pad_out_o & ~port4_pad_oe_n_o}, {3'h1, 3'h6})
        `CHK({port5_pad_oe_n_o, port5_pad_out_o & ~port5_pad_oe_n_o}, {6'h0b, 6'h34})
        `CHK({port6_pad_oe_n_o, port6_pad_out_o & ~port6_pad_oe_n_o}, {16'hde40, 16'h21bf})
        `CHK({port8_pad_oe_n_o, port8_pad_out_o & ~port8_pad_oe_n_o}, {2'h2, 2'h1})
        `CHK({async_serial0_receive_o, async_serial0_baud_clock_in_o, timer16_in_a_o,
            two_wire0_data_in_o, two_wire0_clock_in_o, clocked_serial00_in_o, timer16_in_b_o,
            timer8_in_o, clocked_serial_a0_in_o, clocked_serial02_in_o, timer16_in_c_o,
            async_serial2_receive_o}, 17'h1ffff)
        @(posedge clk_i);
        {e3, e4, e5, e6, e8} <= '1;
        settle(7);
        `CHK({async_serial0_receive_o, async_serial0_baud_clock_in_o, timer16_in_a_o,
            two_wire0_data_in_o, two_wire0_clock_in_o, clocked_serial00_in_o, timer16_in_b_o,
            timer8_in_o, clocked_serial_a0_in_o, clocked_serial02_in_o, timer16_in_c_o,
            async_serial2_receive_o}, 17'h0)
        `CHK({clocked_serial00_clock_in_o, clocked_serial_a0_clock_in_o,
            clocked_serial02_clock_in_o, two_wire1_data_in_o, two_wire1_clock_in_o}, 5'h1e)
        `CHK({port4_read_o, port5_read_o, port6_read_o, port8_read_o},
            {3'h6, 6'h34, 16'h21bf, 2'h1})
    endtask : control_mode1
    task automatic control_mode2();
        @(posedge clk_i);
        {port3_alt_mode_select_i, port5_alt_mode_select_i} <= '1;
        {port6_alt_mode_select_i, port8_alt_mode_select_i} <= '1;
        {port4_open_drain_i, port5_open_drain_i} <= {3'h6, 6'h30};
        periph_drive <= 36'hdffffffb6;
        settle(2);
        `CHK({port3_pad_oe_n_o, port3_pad_out_o & ~port3_pad_oe_n_o}, {10'h3d6, 10'h021})
        `CHK(port4_pad_oe_n_o, 3'h7)
        `CHK({port5_pad_oe_n_o, port5_pad_out_o & ~port5_pad_oe_n_o}, {6'h30, 6'h0f})
        `CHK({port6_pad_oe_n_o, port6_pad_out_o & ~port6_pad_oe_n_o}, {16'hde40, 16'h01bf})
        `CHK({port8_pad_oe_n_o, port8_pad_out_o & ~port8_pad_oe_n_o}, {2'h2, 2'h0})
    endtask : control_mode2
    task automatic key_inputs();
        int n;
        @(posedge clk_i);
        {port5_function_select_i, port5_direction_i} <= {6'h0, 6'h3b};
        {key_return_config_i, x5} <= {6'h05, 6'h3f};
        n = 0;
        while (key_interrupt_inputs_o === 6'h0 && n < 12)
        begin
            settle(1);
            n++;
        end
        if (n == 12)
        begin
            mismatches++;
            end_of_test();
        end
        settle(2);
        `CHK(key_interrupt_inputs_o, 6'h01)
        @(posedge clk_i);
        key_return_config_i <= 6'h0;
        settle(2);
        `CHK(key_interrupt_inputs_o, 6'h00)
    endtask : key_inputs
    task automatic input_only();
        @(posedge clk_i);
        port7_pad_in_i <= 16'ha53c;
        settle(7);
        `CHK({port7_read_o, converter_analog_inputs_o}, {16'ha53c, 16'ha53c})
    endtask : input_only
    initial
    begin
        {clk_i, srst_i, mismatches, compares} = {1'b0, 1'b1, 64'h0};
        {port3_direction_i, port4_direction_i, port5_direction_i} = '1;
        {port6_direction_i, port8_direction_i} = '1;
        {port3_function_select_i, port3_alt_mode_select_i, port3_latch_i, e3, x3} = '0;
        {port4_function_select_i, port4_open_drain_i, port4_latch_i, e4, x4} = '0;
        {port5_function_select_i, port5_alt_mode_select_i, port5_open_drain_i} = '0;
        {port5_latch_i, e5, x5, key_return_config_i, periph_drive, port7_pad_in_i} = '0;
        {port6_function_select_i, port6_alt_mode_select_i, port6_open_drain_i} = '0;
        {port6_latch_i, e6, x6, port8_latch_i, e8, x8} = '0;
        {port8_function_select_i, port8_alt_mode_select_i} = '0;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        port_mode();
        control_mode1();
        control_mode2();
        key_inputs();
        input_only();
        end_of_test();
    end
endmodule : tb

// ===== verilog/port3_to_port8_pin_mux.sv
`timescale 1ns/1ps
`include "pin_mux_map.svh"

module port3_to_port8_pin_mux #(
    parameter bit TWO_WIRE_PRESENT = 1'b1
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire pin_mux_pkg::p3_t port3_direction_i,
    input wire pin_mux_pkg::p3_t port3_function_select_i,
    input wire pin_mux_pkg::p3_t port3_alt_mode_select_i,
    input wire pin_mux_pkg::p3_t port3_latch_i,
    input wire pin_mux_pkg::p3_t port3_pad_in_i,
    output logic [`P3_W-1:0] port3_pad_out_o,
    output logic [`P3_W-1:0] port3_pad_oe_n_o,
    output logic [`P3_W-1:0] port3_read_o,
    input wire pin_mux_pkg::p4_t port4_direction_i,
    input wire pin_mux_pkg::p4_t port4_function_select_i,
    input wire pin_mux_pkg::p4_t port4_open_drain_i,
    input wire pin_mux_pkg::p4_t port4_latch_i,
    input wire pin_mux_pkg::p4_t port4_pad_in_i,
    output logic [`P4_W-1:0] port4_pad_out_o,
    output logic [`P4_W-1:0] port4_pad_oe_n_o,
    output logic [`P4_W-1:0] port4_read_o,
    input wire pin_mux_pkg::p5_t port5_direction_i,
    input wire pin_mux_pkg::p5_t port5_function_select_i,
    input wire pin_mux_pkg::p5_t port5_alt_mode_select_i,
    input wire pin_mux_pkg::p5_t port5_open_drain_i,
    input wire pin_mux_pkg::p5_t port5_latch_i,
    input wire pin_mux_pkg::p5_t port5_pad_in_i,
    output logic [`P5_W-1:0] port5_pad_out_o,
    output logic [`P5_W-1:0] port5_pad_oe_n_o,
    output logic [`P5_W-1:0] port5_read_o,
    input wire pin_mux_pkg::p6_t port6_direction_i,
    input wire pin_mux_pkg::p6_t port6_function_select_i,
    input wire pin_mux_pkg::p6_t port6_alt_mode_select_i,
    input wire pin_mux_pkg::p6_t port6_open_drain_i,
    input wire pin_mux_pkg::p6_t port6_latch_i,
    input wire pin_mux_pkg::p6_t port6_pad_in_i,
    output logic [`P6_W-1:0] port6_pad_out_o,
    output logic [`P6_W-1:0] port6_pad_oe_n_o,
    output logic [`P6_W-1:0] port6_read_o,
    input wire pin_mux_pkg::p7_t port7_pad_in_i,
    output logic [`P7_W-1:0] port7_read_o,
    output logic [`P7_W-1:0] converter_analog_inputs_o,
    input wire pin_mux_pkg::p8_t port8_direction_i,
    input wire pin_mux_pkg::p8_t port8_function_select_i,
    input wire pin_mux_pkg::p8_t port8_alt_mode_select_i,
    input wire pin_mux_pkg::p8_t port8_latch_i,
    input wire pin_mux_pkg::p8_t port8_pad_in_i,
    output logic [`P8_W-1:0] port8_pad_out_o,
    output logic [`P8_W-1:0] port8_pad_oe_n_o,
    output logic [`P8_W-1:0] port8_read_o,
    input wire pin_mux_pkg::p5_t key_return_config_i,
    output logic [`P5_W-1:0] key_interrupt_inputs_o,
    input wire logic async_serial0_transmit_i,
    output logic async_serial0_receive_o,
    output logic async_serial0_baud_clock_in_o,
    output logic [2:0] timer16_in_a_o,
    input wire logic [1:0] timer16_out_a_i,
    input wire logic two_wire0_data_out_i,
    input wire logic two_wire0_data_oe_i,
    output logic two_wire0_data_in_o,
    input wire logic two_wire0_clock_out_i,
    input wire logic two_wire0_clock_oe_i,
    output logic two_wire0_clock_in_o,
    input wire logic clocked_serial00_out_i,
    output logic clocked_serial00_in_o,
    input wire logic clocked_serial00_clock_out_i,
    input wire logic clocked_serial00_clock_oe_i,
    output logic clocked_serial00_clock_in_o,
    output logic timer16_in_b_o,
    output logic timer8_in_o,
    input wire logic timer8_out_i,
    input wire logic clocked_serial_a0_out_i,
    output logic clocked_serial_a0_in_o,
    input wire logic clocked_serial_a0_clock_out_i,
    input wire logic clocked_serial_a0_clock_oe_i,
    output logic clocked_serial_a0_clock_in_o,
    input wire pin_mux_pkg::p5_t realtime_output_group0_i,
    input wire logic [5:0] realtime_output_group1_i,
    input wire logic clocked_serial02_out_i,
    output logic clocked_serial02_in_o,
    input wire logic clocked_serial02_clock_out_i,
    input wire logic clocked_serial02_clock_oe_i,
    output logic clocked_serial02_clock_in_o,
    output logic [3:0] timer16_in_c_o,
    input wire logic [1:0] timer16_out_c_i,
    input wire logic async_serial2_transmit_i,
    output logic async_serial2_receive_o,
    input wire logic two_wire1_data_out_i,
    input wire logic two_wire1_data_oe_i,
    output logic two_wire1_data_in_o,
    input wire logic two_wire1_clock_out_i,
    input wire logic two_wire1_clock_oe_i,
    output logic two_wire1_clock_in_o
);
    import pin_mux_pkg::*;

    // ==========================================================
    // Pin drive resolution
    function automatic pin_s resolve(input logic pm, input logic alt, input logic dir,
                                     input logic lat, input logic o1, input logic e1,
                                     input logic o2, input logic e2, input logic od);
        pin_s r;
        r.val = pm ? (alt ? o2 : o1) : lat;
        r.drv = pm ? (alt ? e2 : e1) : ~dir;
        if (od && r.val)
        begin
            r.drv = 1'b0;
        end
        return r;
    endfunction : resolve

    io_t fsel_all;
    io_t alt_all;
    io_t dir_all;
    io_t lat_all;
    io_t od_all;
    io_t c1o;
    io_t c1e;
    io_t c2o;
    io_t c2e;
    io_t out_d;
    io_t out_q;
    io_t oe_n_d;
    io_t oe_n_q;
    in_t pad_all;
    in_t s1_q;
    in_t s2_q;
    in_t s3_q;
    in_t stab_d;
    in_t stab_q;
    p5_t key_d;
    p5_t key_q;
    pin_s res;
    logic tw;

    assign tw = TWO_WIRE_PRESENT;

    // ==========================================================
    // Merged configuration vectors
    assign fsel_all = {port8_function_select_i, port6_function_select_i,
                       port5_function_select_i, port4_function_select_i,
                       port3_function_select_i};
    assign alt_all = {port8_alt_mode_select_i, port6_alt_mode_select_i & `P6_ALT_MASK,
                      port5_alt_mode_select_i, {`P4_W{1'b0}},
                      port3_alt_mode_select_i & `P3_ALT_MASK};
    assign dir_all = {port8_direction_i, port6_direction_i, port5_direction_i,
                      port4_direction_i, port3_direction_i};
    assign lat_all = {port8_latch_i, port6_latch_i, port5_latch_i,
                      port4_latch_i, port3_latch_i};
    assign od_all = {{`P8_W{1'b0}}, port6_open_drain_i & `P6_OD_SEL,
                     port5_open_drain_i & `P5_OD_SEL, port4_open_drain_i & `P4_OD_SEL,
                     `P3_OD_FIXED};
    assign pad_all = {port7_pad_in_i, port8_pad_in_i, port6_pad_in_i,
                      port5_pad_in_i, port4_pad_in_i, port3_pad_in_i};

    // ==========================================================
    // Peripheral output routing
    always_comb
    begin
        c1o = '0;
        c1e = '0;
        c2o = '0;
        c2e = '0;
        c1o[`P3_B+`P3_TX] = async_serial0_transmit_i;
        c1e[`P3_B+`P3_TX] = 1'b1;
        c2o[`P3_B+`P3_TO_A] = timer16_out_a_i[0];
        c2e[`P3_B+`P3_TO_A] = 1'b1;
        c2o[`P3_B+`P3_TO_B] = timer16_out_a_i[1];
        c2e[`P3_B+`P3_TO_B] = 1'b1;
        c1o[`P3_B+`P3_SDA] = two_wire0_data_out_i;
        c1e[`P3_B+`P3_SDA] = two_wire0_data_oe_i & tw;
        c1o[`P3_B+`P3_SCL] = two_wire0_clock_out_i;
        c1e[`P3_B+`P3_SCL] = two_wire0_clock_oe_i & tw;
        c1o[`P4_B+`P4_SO] = clocked_serial00_out_i;
        c1e[`P4_B+`P4_SO] = 1'b1;
        c1o[`P4_B+`P4_SCK] = clocked_serial00_clock_out_i;
        c1e[`P4_B+`P4_SCK] = clocked_serial00_clock_oe_i;
        c1o[`P5_B+`P5_TO8] = timer8_out_i;
        c1e[`P5_B+`P5_TO8] = 1'b1;
        c1o[`P5_B+`P5_SO] = clocked_serial_a0_out_i;
        c1e[`P5_B+`P5_SO] = 1'b1;
        c1o[`P5_B+`P5_SCK] = clocked_serial_a0_clock_out_i;
        c1e[`P5_B+`P5_SCK] = clocked_serial_a0_clock_oe_i;
        c2o[`P5_B +: `P5_W] = realtime_output_group0_i;
        c2e[`P5_B +: `P5_W] = {`P5_W{1'b1}};
        c1o[`P6_B+`P6_RTP +: 6] = realtime_output_group1_i;
        c1e[`P6_B+`P6_RTP +: 6] = 6'h3f;
        c1o[`P6_B+`P6_SO] = clocked_serial02_out_i;
        c1e[`P6_B+`P6_SO] = 1'b1;
        c1o[`P6_B+`P6_SCK] = clocked_serial02_clock_out_i;
        c1e[`P6_B+`P6_SCK] = clocked_serial02_clock_oe_i;
        c1o[`P6_B+`P6_TO] = timer16_out_c_i[0];
        c1e[`P6_B+`P6_TO] = 1'b1;
        c2o[`P6_B+`P6_TO] = timer16_out_c_i[1];
        c2e[`P6_B+`P6_TO] = 1'b1;
        c1o[`P8_B+`P8_TX] = async_serial2_transmit_i;
        c1e[`P8_B+`P8_TX] = 1'b1;
        c2o[`P8_B+`P8_TX] = two_wire1_data_out_i;
        c2e[`P8_B+`P8_TX] = two_wire1_data_oe_i & tw;
        c2o[`P8_B+`P8_RX] = two_wire1_clock_out_i;
        c2e[`P8_B+`P8_RX] = two_wire1_clock_oe_i & tw;
    end

    // ==========================================================
    // Pin output next state
    always_comb
    begin
        out_d = out_q;
        oe_n_d = oe_n_q;
        res = '0;
        for (int i = 0; i < `IO_W; i++)
        begin
            res = resolve(fsel_all[i], alt_all[i], dir_all[i], lat_all[i],
                          c1o[i], c1e[i], c2o[i], c2e[i], od_all[i]);
            out_d[i] = res.val;
            oe_n_d[i] = ~res.drv;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            out_q <= `OUT_RST;
            oe_n_q <= `OE_N_RST;
        end
        else
        begin
            out_q <= out_d;
            oe_n_q <= oe_n_d;
        end
    end

    // ==========================================================
    // Pin input synchroniser and key return
    always_comb
    begin
        stab_d = stab_q;
        for (int i = 0; i < `IN_W; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                stab_d[i] = s3_q[i];
            end
        end
        key_d = stab_q[`P5_B +: `P5_W] & key_return_config_i & port5_direction_i
                & ~port5_function_select_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s1_q <= `IN_RST;
            s2_q <= `IN_RST;
            s3_q <= `IN_RST;
            stab_q <= `IN_RST;
            key_q <= '0;
        end
        else
        begin
            s1_q <= pad_all;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stab_q <= stab_d;
            key_q <= key_d;
        end
    end

    // ==========================================================
    // Outputs
    assign port3_pad_out_o = out_q[`P3_B +: `P3_W];
    assign port3_pad_oe_n_o = oe_n_q[`P3_B +: `P3_W];
    assign port3_read_o = stab_q[`P3_B +: `P3_W];
    assign port4_pad_out_o = out_q[`P4_B +: `P4_W];
    assign port4_pad_oe_n_o = oe_n_q[`P4_B +: `P4_W];
    assign port4_read_o = stab_q[`P4_B +: `P4_W];
    assign port5_pad_out_o = out_q[`P5_B +: `P5_W];
    assign port5_pad_oe_n_o = oe_n_q[`P5_B +: `P5_W];
    assign port5_read_o = stab_q[`P5_B +: `P5_W];
    assign port6_pad_out_o = out_q[`P6_B +: `P6_W];
    assign port6_pad_oe_n_o = oe_n_q[`P6_B +: `P6_W];
    assign port6_read_o = stab_q[`P6_B +: `P6_W];
    assign port7_read_o = stab_q[`P7_B +: `P7_W];
    assign converter_analog_inputs_o = stab_q[`P7_B +: `P7_W];
    assign port8_pad_out_o = out_q[`P8_B +: `P8_W];
    assign port8_pad_oe_n_o = oe_n_q[`P8_B +: `P8_W];
    assign port8_read_o = stab_q[`P8_B +: `P8_W];
    assign key_interrupt_inputs_o = key_q;

    assign async_serial0_receive_o = stab_q[`P3_B+`P3_RX];
    assign async_serial0_baud_clock_in_o = stab_q[`P3_B+`P3_BAUD];
    assign timer16_in_a_o = stab_q[`P3_B+`P3_TMR +: 3];
    assign two_wire0_data_in_o = tw ? stab_q[`P3_B+`P3_SDA] : 1'b1;
    assign two_wire0_clock_in_o = tw ? stab_q[`P3_B+`P3_SCL] : 1'b1;
    assign clocked_serial00_in_o = stab_q[`P4_B+`P4_SI];
    assign clocked_serial00_clock_in_o = stab_q[`P4_B+`P4_SCK];
    assign timer16_in_b_o = stab_q[`P5_B+`P5_TI16];
    assign timer8_in_o = stab_q[`P5_B+`P5_TI8];
    assign clocked_serial_a0_in_o = stab_q[`P5_B+`P5_SI];
    assign clocked_serial_a0_clock_in_o = stab_q[`P5_B+`P5_SCK];
    assign clocked_serial02_in_o = stab_q[`P6_B+`P6_SI];
    assign clocked_serial02_clock_in_o = stab_q[`P6_B+`P6_SCK];
    assign timer16_in_c_o = stab_q[`P6_B+`P6_TI +: 4];
    assign async_serial2_receive_o = stab_q[`P8_B+`P8_RX];
    assign two_wire1_data_in_o = tw ? stab_q[`P8_B+`P8_TX] : 1'b1;
    assign two_wire1_clock_in_o = tw ? stab_q[`P8_B+`P8_RX] : 1'b1;

endmodule : port3_to_port8_pin_mux
